// ### verilog/cpu_status_map.vh
// Register map and field constants for the core status registers
//
// Contract
// [R1] Flag ops block writes to zero and carry bits
// [R2] Carry and digit carry mean borrow in subtract
// [R3] Overflow set when signed result leaves range
// [R4] Two-operand ops use working register plus file/literal
// [R5] Single-operand ops use working register or file
// [R6] Arith flag register at 04h, fixed bit layout
// [R7] Subtract adds two's complement, carry from sum
// [R8] Rotate through carry loads carry from end bit
// [R9] Core control register at 06h, fixed bit layout
// [R10] Expiry, sleep, stack-room bits ignore writes
// [R11] Stack-room clears at Fh, wrap holds till reset
// [R12] Inhibit blocks all interrupts, else enabled only
// [R13] Expiry flag set at power-up/clear, cleared timeout
// [R14] Sleep flag set at power-up/clear, cleared halt
// [R15] Timer-0 control bit 7 selects interrupt edge
// [R16] Pointer mode fields pick post dec/inc/none
// [R17] Zero flag follows result equal zero
// [R18] Digit carry from bit 3 into bit 4
`ifndef CPU_STATUS_MAP_VH
`define CPU_STATUS_MAP_VH

// ------------------------------------------------------------
// Addresses
// ------------------------------------------------------------
`define ADDR_ARITH_FLAGS   8'h04
`define ADDR_TIMER0_CTRL   8'h05
`define ADDR_CORE_CTRL     8'h06

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define BIT_CARRY          0
`define BIT_DIGIT_CARRY    1
`define BIT_ZERO           2
`define BIT_OVERFLOW       3
`define BIT_PTR0_MODE_LO   4
`define BIT_PTR0_MODE_HI   5
`define BIT_PTR1_MODE_LO   6
`define BIT_PTR1_MODE_HI   7
`define BIT_SLEEP          2
`define BIT_WDT_EXPIRY     3
`define BIT_IRQ_INHIBIT    4
`define BIT_STACK_ROOM     5
`define BIT_EDGE_SELECT    7

// ------------------------------------------------------------
// Reset values and operation codes
// ------------------------------------------------------------
`define ARITH_RESET        8'h00
`define CORE_CTRL_RESET    8'h3c
`define TIMER0_RESET       8'h00
`define STACK_TOP          4'hf
`define PTR_MODE_DEC       2'h0
`define PTR_MODE_INC       2'h1

`define OP_NONE            4'h0
`define OP_ADD             4'h1
`define OP_SUB             4'h2
`define OP_AND             4'h3
`define OP_IOR             4'h4
`define OP_XOR             4'h5
`define OP_RLC             4'h6
`define OP_RRC             4'h7
`define OP_INC             4'h8
`define OP_DEC             4'h9
`define OP_CLR             4'ha
`define OP_MOVE            4'hb

`endif

// ### verilog/alu_flag_unit.v
// Arithmetic unit that computes a result and its status flags
`timescale 1ns/1ps
`default_nettype none
`include "cpu_status_map.vh"
module alu_flag_unit #(
  parameter WIDTH = 8
) (
  // Operands and operation
  input  wire [3:0]       op_code,
  input  wire [WIDTH-1:0] operand_a,
  input  wire [WIDTH-1:0] operand_b,
  input  wire             carry_in,
  // Result and flags
  output reg  [WIDTH-1:0] result,
  output reg              carry_out,
  output reg              digit_carry_out,
  output reg              overflow_out,
  output wire             zero_out,
  output reg              arith_op,
  output reg              logic_op
);
  wire [WIDTH:0] b_use;
  wire [WIDTH:0] sum;
  wire [4:0]     nib;
  wire           subtract;

  // Subtract is add of the inverted operand plus one, so carry is
  // naturally a not-borrow; see [R7] see [R2]
  assign subtract = (op_code == `OP_SUB) || (op_code == `OP_DEC);
  assign b_use = subtract ? {1'b0, ~operand_b} : {1'b0, operand_b};
  assign sum   = {1'b0, operand_a} + b_use + {{WIDTH{1'b0}}, subtract};
  assign nib   = {1'b0, operand_a[3:0]} + {1'b0, b_use[3:0]}
               + {4'h0, subtract};
  assign zero_out = (result == {WIDTH{1'b0}}); // see [R17]

  // Result and flag select
  always @* begin
    result = operand_a;
    carry_out = carry_in;
    digit_carry_out = 1'b0;
    overflow_out = 1'b0;
    arith_op = 1'b0;
    logic_op = 1'b1;
    case (op_code)
      `OP_ADD, `OP_SUB, `OP_INC, `OP_DEC: begin
        result = sum[WIDTH-1:0];
        carry_out = sum[WIDTH];
        digit_carry_out = nib[4]; // see [R18]
        // Same-sign inputs giving other-sign sum      see [R3]
        overflow_out = (operand_a[WIDTH-1] == b_use[WIDTH-1]) &&
                       (sum[WIDTH-1] != operand_a[WIDTH-1]);
        arith_op = 1'b1;
      end
      `OP_AND: result = operand_a & operand_b;
      `OP_IOR: result = operand_a | operand_b;
      `OP_XOR: result = operand_a ^ operand_b;
      `OP_RLC: begin
        result = {operand_a[WIDTH-2:0], carry_in};
        carry_out = operand_a[WIDTH-1]; // see [R8]
        logic_op = 1'b0;
      end
      `OP_RRC: begin
        result = {carry_in, operand_a[WIDTH-1:1]};
        carry_out = operand_a[0]; // see [R8]
        logic_op = 1'b0;
      end
      `OP_CLR: result = {WIDTH{1'b0}};
      default: logic_op = 1'b0;
    endcase
  end
endmodule // alu_flag_unit
`default_nettype wire

// ### verilog/stack_room_tracker.v
// Stack pointer and stack-room flag tracking
`timescale 1ns/1ps
`default_nettype none
`include "cpu_status_map.vh"
module stack_room_tracker (
  // Clock and reset
  input  wire       clk_sys,
  input  wire       reset_n,
  // Stack events
  input  wire       push_evt,
  input  wire       pop_evt,
  // State
  output reg  [3:0] stack_ptr_reg,
  output reg        stack_room_reg
);
  reg [3:0] stack_ptr_next;
  reg       wrapped_reg;
  reg       wrapped_next;

  // Pointer moves on a push or a pop alone; a push past the top latches until reset
  always @* begin
    stack_ptr_next = stack_ptr_reg;
    wrapped_next = wrapped_reg;
    if (push_evt && !pop_evt) begin
      stack_ptr_next = stack_ptr_reg + 4'h1;
      if (stack_ptr_reg == `STACK_TOP)
        wrapped_next = 1'b1; // see [R11]
    end else if (pop_evt && !push_evt) begin
      stack_ptr_next = stack_ptr_reg - 4'h1;
    end
  end

  // Registered flag; low at top of stack or after a wrap
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      stack_ptr_reg  <= 4'h0;
      wrapped_reg    <= 1'b0;
      stack_room_reg <= 1'b1;
    end else begin
      stack_ptr_reg  <= stack_ptr_next;
      wrapped_reg    <= wrapped_next;
      stack_room_reg <= !(wrapped_next ||
                          stack_ptr_next == `STACK_TOP); // see [R11]
    end
  end
endmodule // stack_room_tracker
`default_nettype wire

// ### verilog/cpu_alu_status_registers.v
// Core status registers: arithmetic flags, core control, timer-0 edge bit
`timescale 1ns/1ps
`default_nettype none
`include "cpu_status_map.vh"
module cpu_alu_status_registers #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input  wire             clk_sys,
  input  wire             reset_n,
  // Instruction execution
  input  wire             exec_valid,
  input  wire [3:0]       op_code,
  input  wire             src_is_literal,
  input  wire             single_src_is_file,
  input  wire [WIDTH-1:0] working_register,
  input  wire [WIDTH-1:0] file_operand,
  input  wire [WIDTH-1:0] literal_operand,
  input  wire             flags_affected,
  input  wire             dest_write,
  input  wire [7:0]       dest_addr,
  input  wire [7:0]       read_addr,
  // Core events
  input  wire             watchdog_clear_op,
  input  wire             watchdog_timeout,
  input  wire             sleep_op,
  input  wire             push_evt,
  input  wire             pop_evt,
  input  wire             indirect0_access,
  input  wire             indirect1_access,
  input  wire [7:0]       irq_pending,
  input  wire [7:0]       irq_enable,
  // Results
  output reg  [WIDTH-1:0] alu_result_reg,
  output reg  [7:0]       read_data_reg,
  output reg  [7:0]       indirect_pointer_0,
  output reg  [7:0]       indirect_pointer_1,
  output reg              irq_request_reg,
  output reg              ext_irq_rising_reg,
  output reg              stack_room_out_reg
);
  // ------------------------------------------------------------
  // Operand routing
  // ------------------------------------------------------------
  reg  [7:0]       arith_flags_and_pointer_modes;
  reg  [7:0]       core_control_and_status;
  reg  [7:0]       timer0_control_reg;
  reg  [WIDTH-1:0] operand_a;
  reg  [WIDTH-1:0] operand_b;
  wire [WIDTH-1:0] alu_result;
  wire             alu_carry;
  wire             alu_half_carry;
  wire             alu_overflow;
  wire             alu_zero;
  wire             alu_arith;
  wire             alu_logic;
  wire [3:0]       stack_ptr;
  wire             stack_room;
  wire             single_op;

  // Single-operand ops take working reg or file; two-operand ops
  // always pair the working register with file or literal
  assign single_op = (op_code == `OP_RLC) || (op_code == `OP_RRC) ||
                     (op_code == `OP_INC) || (op_code == `OP_DEC) ||
                     (op_code == `OP_CLR) || (op_code == `OP_MOVE);
  always @* begin
    if (single_op) begin
      operand_a = single_src_is_file ? file_operand
                                     : working_register; // see [R5]
      operand_b = {{(WIDTH-1){1'b0}}, 1'b1};
      if (op_code == `OP_RLC || op_code == `OP_RRC ||
          op_code == `OP_CLR || op_code == `OP_MOVE)
        operand_b = {WIDTH{1'b0}};
    end else begin
      operand_a = working_register; // see [R4]
      operand_b = src_is_literal ? literal_operand : file_operand;
    end
  end

  alu_flag_unit #(
    .WIDTH(WIDTH)
  ) u_alu (
    .op_code        (op_code),
    .operand_a      (operand_a),
    .operand_b      (operand_b),
    .carry_in       (arith_flags_and_pointer_modes[`BIT_CARRY]),
    .result         (alu_result),
    .carry_out      (alu_carry),
    .digit_carry_out(alu_half_carry),
    .overflow_out   (alu_overflow),
    .zero_out       (alu_zero),
    .arith_op       (alu_arith),
    .logic_op       (alu_logic)
  );

  stack_room_tracker u_stack (
    .clk_sys       (clk_sys),
    .reset_n       (reset_n),
    .push_evt      (push_evt),
    .pop_evt       (pop_evt),
    .stack_ptr_reg (stack_ptr),
    .stack_room_reg(stack_room)
  );

  // ------------------------------------------------------------
  // Arithmetic flag register
  // ------------------------------------------------------------
  reg [7:0] arith_next;
  wire      wr_arith;
  wire      do_exec;
  wire      updates_zdc;

  assign do_exec  = exec_valid;
  assign wr_arith = do_exec && dest_write &&
                    (dest_addr == `ADDR_ARITH_FLAGS); // see [R6]
  assign updates_zdc = do_exec && flags_affected &&
                       (alu_arith || alu_logic ||
                        op_code == `OP_RLC || op_code == `OP_RRC);

  // Register write first, then flag logic overrides the zero and both
  // carry bits when the op touches them, so the written value loses
  always @* begin
    arith_next = arith_flags_and_pointer_modes;
    if (wr_arith)
      arith_next = alu_result[7:0];
    if (updates_zdc) begin
      if (wr_arith) begin
        arith_next[`BIT_ZERO] =
          arith_flags_and_pointer_modes[`BIT_ZERO]; // see [R1]
        arith_next[`BIT_DIGIT_CARRY] =
          arith_flags_and_pointer_modes[`BIT_DIGIT_CARRY];
        arith_next[`BIT_CARRY] =
          arith_flags_and_pointer_modes[`BIT_CARRY];
      end
      if (alu_arith || alu_logic)
        arith_next[`BIT_ZERO] = alu_zero; // see [R17]
      if (alu_arith) begin
        arith_next[`BIT_DIGIT_CARRY] = alu_half_carry; // see [R18] see [R2]
        arith_next[`BIT_OVERFLOW] = alu_overflow; // see [R3]
        arith_next[`BIT_CARRY] = alu_carry; // see [R7] see [R2]
      end
      if (op_code == `OP_RLC || op_code == `OP_RRC)
        arith_next[`BIT_CARRY] = alu_carry; // see [R8]
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n)
      arith_flags_and_pointer_modes <= `ARITH_RESET;
    else
      arith_flags_and_pointer_modes <= arith_next;
  end

  // ------------------------------------------------------------
  // Core control register and timer-0 edge bit
  // ------------------------------------------------------------
  wire wr_core;
  wire wr_timer0;
  assign wr_core   = do_exec && dest_write && (dest_addr == `ADDR_CORE_CTRL);
  assign wr_timer0 = do_exec && dest_write && (dest_addr == `ADDR_TIMER0_CTRL);

  // Only the inhibit bit is writable; expiry, sleep and stack-room
  // follow device events. Clear op wins over a same-cycle timeout.
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      core_control_and_status <= `CORE_CTRL_RESET;
      timer0_control_reg      <= `TIMER0_RESET;
    end else begin
      if (wr_core)
        core_control_and_status[`BIT_IRQ_INHIBIT] <=
          alu_result[`BIT_IRQ_INHIBIT]; // see [R10] see [R9]
      if (watchdog_clear_op) begin
        core_control_and_status[`BIT_WDT_EXPIRY] <= 1'b1; // see [R13]
        core_control_and_status[`BIT_SLEEP] <= 1'b1; // see [R14]
      end else begin
        if (watchdog_timeout)
          core_control_and_status[`BIT_WDT_EXPIRY] <= 1'b0; // see [R13]
        if (sleep_op)
          core_control_and_status[`BIT_SLEEP] <= 1'b0; // see [R14]
      end
      core_control_and_status[`BIT_STACK_ROOM] <= stack_room; // see [R11]
      if (wr_timer0)
        timer0_control_reg[7:1] <= alu_result[7:1]; // see [R15]
    end
  end

  // ------------------------------------------------------------
  // Pointer update, interrupt gate, read port
  // ------------------------------------------------------------
  wire [1:0] mode0;
  wire [1:0] mode1;
  assign mode0 = arith_flags_and_pointer_modes[`BIT_PTR0_MODE_HI:
                                               `BIT_PTR0_MODE_LO];
  assign mode1 = arith_flags_and_pointer_modes[`BIT_PTR1_MODE_HI:
                                               `BIT_PTR1_MODE_LO];

  // Modes 1x leave the pointer unchanged
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      indirect_pointer_0 <= 8'h00;
      indirect_pointer_1 <= 8'h00;
    end else begin
      if (indirect0_access && mode0 == `PTR_MODE_DEC)
        indirect_pointer_0 <= indirect_pointer_0 - 8'h01; // see [R16]
      else if (indirect0_access && mode0 == `PTR_MODE_INC)
        indirect_pointer_0 <= indirect_pointer_0 + 8'h01; // see [R16]
      if (indirect1_access && mode1 == `PTR_MODE_DEC)
        indirect_pointer_1 <= indirect_pointer_1 - 8'h01; // see [R16]
      else if (indirect1_access && mode1 == `PTR_MODE_INC)
        indirect_pointer_1 <= indirect_pointer_1 + 8'h01; // see [R16]
    end
  end

  // Registered outputs; unmapped reads return zero
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      alu_result_reg     <= {WIDTH{1'b0}};
      read_data_reg      <= 8'h00;
      irq_request_reg    <= 1'b0;
      ext_irq_rising_reg <= 1'b0;
      stack_room_out_reg <= 1'b1;
    end else begin
      if (do_exec)
        alu_result_reg <= alu_result;
      if (read_addr == `ADDR_ARITH_FLAGS)
        read_data_reg <= arith_flags_and_pointer_modes;
      else if (read_addr == `ADDR_TIMER0_CTRL)
        read_data_reg <= {timer0_control_reg[7:1], 1'b0};
      else if (read_addr == `ADDR_CORE_CTRL) // see [R9]
        read_data_reg <= {2'h0, core_control_and_status[5:2], 2'h0};
      else
        read_data_reg <= 8'h00;
      irq_request_reg <= !core_control_and_status[`BIT_IRQ_INHIBIT] &&
                         |(irq_pending & irq_enable); // see [R12]
      ext_irq_rising_reg <= timer0_control_reg[`BIT_EDGE_SELECT]; // see [R15]
      stack_room_out_reg <= stack_room;
    end
  end
endmodule // cpu_alu_status_registers
`default_nettype wire

// ### test/cpu_alu_status_registers_sva.sv
// Port-level assertions for the core status register block
`timescale 1ns/1ps
`default_nettype none
`include "cpu_status_map.vh"
module cpu_alu_status_registers_sva (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       reset_n,
  // Execution and reads
  input wire logic       exec_valid,
  input wire logic [3:0] op_code,
  input wire logic       src_is_literal,
  input wire logic       single_src_is_file,
  input wire logic [7:0] working_register,
  input wire logic [7:0] file_operand,
  input wire logic [7:0] literal_operand,
  input wire logic       flags_affected,
  input wire logic       dest_write,
  input wire logic [7:0] dest_addr,
  input wire logic [7:0] read_addr,
  // Events and interrupt levels
  input wire logic       watchdog_clear_op,
  input wire logic       watchdog_timeout,
  input wire logic       sleep_op,
  input wire logic [7:0] irq_pending,
  input wire logic [7:0] irq_enable,
  // Observed outputs
  input wire logic [7:0] alu_result_reg,
  input wire logic [7:0] read_data_reg,
  input wire logic       irq_request_reg,
  input wire logic       ext_irq_rising_reg
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  // Flag-only ops, then a read of 04h with no op in between
  sequence s_rlc;
    exec_valid && op_code == `OP_RLC && flags_affected && !dest_write &&
    !single_src_is_file;
  endsequence
  sequence s_and_lit;
    exec_valid && op_code == `OP_AND && flags_affected && !dest_write &&
    src_is_literal;
  endsequence
  sequence s_rd_flags;
    !exec_valid && read_addr == 8'h04;
  endsequence
  // A clear in the gap would legally set both status bits again
  sequence s_rd_core;
    !watchdog_clear_op && read_addr == 8'h06;
  endsequence

  a_unmapped_read: assert property (
    !(read_addr inside {8'h04, 8'h05, 8'h06}) |=> read_data_reg == 8'h00)
    else $error("unmapped read not zero");
  a_core_pad_bits: assert property (
    read_addr == 8'h06 |=> read_data_reg[7:6] == 2'b00 &&
    read_data_reg[1:0] == 2'b00) else $error("core pad bits set");
  a_add_literal: assert property (
    exec_valid && op_code == `OP_ADD && src_is_literal |=>
    alu_result_reg == $past(working_register + literal_operand))
    else $error("add result wrong");
  a_sub_file: assert property (
    exec_valid && op_code == `OP_SUB && !src_is_literal |=>
    alu_result_reg == $past(working_register - file_operand))
    else $error("subtract result wrong");
  a_rotate_carry: assert property (
    s_rlc ##1 s_rd_flags |=> read_data_reg[0] == $past(working_register[7], 2))
    else $error("rotate carry wrong");
  a_zero_flag: assert property (
    s_and_lit ##1 s_rd_flags |=> read_data_reg[2] ==
    ($past(working_register & literal_operand, 2) == 8'h00))
    else $error("zero flag wrong");
  a_expiry_clear: assert property (
    watchdog_timeout && !watchdog_clear_op ##1 s_rd_core |=> !read_data_reg[3])
    else $error("expiry flag not cleared");
  a_sleep_clear: assert property (
    sleep_op && !watchdog_clear_op ##1 s_rd_core |=> !read_data_reg[2])
    else $error("sleep flag not cleared");
  a_irq_gate: assert property (
    irq_request_reg |-> $past(|(irq_pending & irq_enable)))
    else $error("interrupt without enabled source");
  // The pin output copies the control bit one edge after the write lands
  a_edge_select: assert property (
    exec_valid && dest_write && dest_addr == 8'h05 && op_code == `OP_MOVE &&
    !single_src_is_file |=> ##1 ext_irq_rising_reg ==
    $past(working_register[7], 2)) else $error("edge select wrong");
endmodule // cpu_alu_status_registers_sva

bind cpu_alu_status_registers cpu_alu_status_registers_sva i_sva (.*);
`default_nettype wire

// ### test/cpu_alu_status_registers_tb.sv
// Self-checking bench with a behavioural model of the status registers
`timescale 1ns/1ps
`default_nettype none
`include "cpu_status_map.vh"
module cpu_alu_status_registers_tb;
  // ----------------------------------------------------------
  // Ports, model state and counters
  // ----------------------------------------------------------
  logic        clk_sys, reset_n, exec_valid, src_is_literal;
  logic        single_src_is_file, flags_affected, dest_write;
  logic [3:0]  op_code;
  logic [7:0]  working_register, file_operand, literal_operand;
  logic [7:0]  dest_addr, read_addr, irq_pending, irq_enable;
  logic [6:0]  evt;
  wire         watchdog_clear_op, watchdog_timeout, sleep_op, push_evt;
  wire         pop_evt, indirect0_access, indirect1_access;
  wire  [7:0]  alu_result_reg, read_data_reg;
  wire  [7:0]  indirect_pointer_0, indirect_pointer_1;
  wire         irq_request_reg, ext_irq_rising_reg, stack_room_out_reg;
  logic [7:0]  m_flags, m_core, m_t0, m_p0, m_p1;
  logic [31:0] bnd = 32'hff0f807f;
  logic [27:0] ops = {`OP_RRC, `OP_RLC, `OP_XOR, `OP_IOR, `OP_AND,
                      `OP_SUB, `OP_ADD};
  logic [27:0] evs = {7'h70, 7'h40, 7'h10, 7'h20};
  int          sp, wrapped, k, fail_count, n_tests;
  // One vector for all pulses so a step can raise them together
  assign {watchdog_clear_op, watchdog_timeout, sleep_op, push_evt, pop_evt,
          indirect0_access, indirect1_access} = evt;
  cpu_alu_status_registers i_cpu_alu_status_registers (.*);

  // 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------
  // Driving, model and comparison tasks
  // ----------------------------------------------------------
  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    if (fail_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic do_reset;
    reset_n = 1'b0;
    repeat (10) tick;
    reset_n = 1'b1;
    {m_flags, m_core, m_t0, m_p0, m_p1} = {8'h00, 8'h3c, 24'h0};
    sp = 0;
    wrapped = 0;
  endtask
  function automatic logic [7:0] step(logic [7:0] p, logic [1:0] md, logic en);
    step = !en ? p : md == 2'd0 ? p - 8'h01 : md == 2'd1 ? p + 8'h01 : p;
  endfunction
  task automatic run(input logic [3:0] o, input logic [7:0] wv, fv, lv,
                     input logic lit, sf, fa, dw, input logic [7:0] da);
    logic [7:0] b, nb, r, sa;
    logic [8:0] s;
    logic [4:0] lo;
    logic       c, hc, vf, ar, rot, up;
    b = lit ? lv : fv;
    sa = sf ? fv : wv;
    nb = (o == `OP_SUB) ? ~b : b;
    s = wv + nb + (o == `OP_SUB);
    lo = wv[3:0] + nb[3:0] + (o == `OP_SUB);
    ar = (o == `OP_ADD) || (o == `OP_SUB);
    rot = (o == `OP_RLC) || (o == `OP_RRC);
    up = fa && (ar || rot || o inside {`OP_AND, `OP_IOR, `OP_XOR, `OP_CLR});
    case (o)
      `OP_AND: r = wv & b;
      `OP_IOR: r = wv | b;
      `OP_XOR: r = wv ^ b;
      `OP_RLC: r = {sa[6:0], m_flags[0]};
      `OP_RRC: r = {m_flags[0], sa[7:1]};
      `OP_INC: r = sa + 8'h01;
      `OP_DEC: r = sa - 8'h01;
      `OP_CLR: r = 8'h00;
      `OP_MOVE: r = sa;
      default: r = s[7:0];
    endcase
    {vf, hc, c} = {m_flags[3], m_flags[1], m_flags[0]};
    if (ar) {vf, hc, c} = {wv[7] == nb[7] && r[7] != wv[7], lo[4], s[8]};
    if (rot) c = (o == `OP_RLC) ? sa[7] : sa[0];
    if (up) m_flags[3:0] = {vf, rot ? m_flags[2] : r == 8'h00, hc, c};
    // Flag bits written by the op win over the stored result
    if (dw && da == 8'h04)
      m_flags = up ? {r[7:4], ar ? m_flags[3] : r[3], m_flags[2:0]} : r;
    if (dw && da == 8'h06) m_core[4] = r[4];
    if (dw && da == 8'h05) m_t0 = {r[7:1], 1'b0};
    {op_code, working_register, file_operand, literal_operand} =
      {o, wv, fv, lv};
    {src_is_literal, single_src_is_file, flags_affected} = {lit, sf, fa};
    {exec_valid, dest_write, dest_addr} = {1'b1, dw, da};
    evt = 7'h00;
    tick;
    chk(alu_result_reg, r);
  endtask
  task automatic mv(input logic [7:0] v, input logic [7:0] da);
    run(`OP_MOVE, v, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0, 1'b1, da);
  endtask
  task automatic ev(input logic [6:0] m);
    {exec_valid, dest_write} = 2'b00;
    evt = m;
    m_core[3] = m[6] | (m_core[3] & !m[5]);
    m_core[2] = m[6] | (m_core[2] & !m[4]);
    if (m[3]) wrapped = wrapped | (sp == 15);
    sp = (sp + m[3] + 16 - m[2]) % 16;
    m_core[5] = (sp != 15) && (wrapped == 0);
    m_p0 = step(m_p0, m_flags[5:4], m[1]);
    m_p1 = step(m_p1, m_flags[7:6], m[0]);
    tick;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    {exec_valid, dest_write} = 2'b00;
    evt = 7'h00;
    read_addr = a;
    tick;
    chk(read_data_reg, e);
  endtask
  // The stack flag reaches the core register a cycle late
  task automatic settle;
    repeat (2) ev(7'h00);
    chk({7'h0, stack_room_out_reg}, {7'h0, m_core[5]});
    rd(8'h06, m_core);
  endtask

  // Hang guard, far beyond the few hundred cycles of the sequence
  initial begin
    #200000;
    fail_count++;
    complete_run;
  end

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    {exec_valid, src_is_literal, single_src_is_file, flags_affected} = 4'h0;
    {dest_write, op_code, working_register, file_operand} = 21'h0;
    {literal_operand, dest_addr, read_addr, irq_pending, irq_enable} = 40'h0;
    evt = 7'h00;
    fail_count = 0;
    n_tests = 0;
    void'($urandom(32'h68b046f8));
    do_reset;
    rd(8'h06, 8'h3c);
    rd(8'h05, 8'h00);
    rd(8'h07, 8'h00);
    for (int i = 0; i < 4; i++) begin
      run(i[0] ? `OP_SUB : `OP_ADD, bnd[8*i +: 8], 8'h00, 8'h01, 1'b1, 1'b0,
          1'b1, 1'b0, 8'h00);
      rd(8'h04, m_flags);
    end
    // Random ops back to back, flags read after each pair
    for (int i = 0; i < 40; i++) begin
      k = $urandom % 7;
      repeat (2) run(ops[4*k +: 4], 8'($urandom), 8'($urandom), 8'($urandom),
                     1'($urandom), 1'b0, 1'b1, 1'b0, 8'h00);
      rd(8'h04, m_flags);
    end
    for (int i = 0; i < 4; i++)
      run(i[1] ? `OP_DEC : `OP_INC, 8'($urandom), 8'($urandom), 8'h00, 1'b0,
          i[0], 1'b0, 1'b0, 8'h00);
    mv(8'hf5, 8'h04);
    run(`OP_CLR, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0, 1'b1, 1'b1, 8'h04);
    rd(8'h04, m_flags);
    run(`OP_ADD, 8'hff, 8'h00, 8'h01, 1'b1, 1'b0, 1'b1, 1'b1, 8'h04);
    rd(8'h04, m_flags);
    for (int i = 0; i < 2; i++) begin
      mv(i[0] ? 8'h90 : 8'h40, 8'h04);
      ev(7'h03);
      chk(indirect_pointer_0, m_p0);
      chk(indirect_pointer_1, m_p1);
    end
    irq_pending = 8'h11;
    irq_enable = 8'h01;
    for (int i = 0; i < 3; i++) begin
      if (i < 2) mv(i[0] ? 8'h00 : 8'hff, 8'h06);
      else irq_enable = 8'h00;
      ev(7'h00);
      chk({7'h0, irq_request_reg},
          {7'h0, !m_core[4] && (irq_pending & irq_enable) != 8'h00});
      rd(8'h06, m_core);
    end
    for (int i = 0; i < 4; i++) begin
      ev(evs[7*i +: 7]);
      rd(8'h06, m_core);
    end
    for (int i = 0; i < 2; i++) begin
      mv(i[0] ? 8'h7f : 8'hff, 8'h05);
      rd(8'h05, m_t0);
      chk({7'h0, ext_irq_rising_reg}, {7'h0, m_t0[7]});
    end
    // Fill to the top, back off, then wrap and check the latch
    repeat (15) ev(7'h08);
    settle;
    ev(7'h04);
    settle;
    repeat (2) ev(7'h08);
    repeat (2) ev(7'h04);
    settle;
    do_reset;
    settle;
    complete_run;
  end
endmodule // cpu_alu_status_registers_tb
`default_nettype wire
